// ===== hdl/i2c_ctrl_defines.vh
`ifndef I2C_CTRL_DEFINES_VH
`define I2C_CTRL_DEFINES_VH

// Register byte addresses on the APB side.
`define ADDR_W            16
`define OFS_BUS_CONTROL   16'hffa8
`define OFS_BUS_STATUS    16'hffac
`define OFS_SLAVE_ADDR    16'hffb0
`define OFS_SHIFT_DATA    16'hffb4

// Field positions of bus_control.
`define CTL_ENABLE        7
`define CTL_EXIT          6
`define CTL_WCANCEL       5
`define CTL_SPIE          4
`define CTL_WTIM          3
`define CTL_ACKE          2
`define CTL_STT           1
`define CTL_SPT           0
`define CTL_RESET         8'h00
`define CTL_READ_MASK     8'hfd

// Field positions of bus_status.
`define STS_MSTS          7
`define STS_COI           6
`define STS_EXC           5
`define STS_WAIT          4
`define STS_TRC           3
`define STS_ACKD          2
`define STS_STD           1
`define STS_SPD           0

// Serial byte framing and the extension code pattern in the first byte.
`define BIT_AT_8TH_FALL   4'h7
`define BIT_AT_9TH_FALL   4'h8
`define EXT_CODE_NIB      4'h0

// Timing: half period of the generated serial clock and start/stop holds.
`define SCL_HALF_NS       5000
`define CLK_FREQ_KHZ      50000
`define KHZ_NS_PER_CYCLE  1000000

`endif

// ===== hdl/line_sync.v
`timescale 1ns/100ps

// Two-flop synchroniser for the open-drain line levels.
// Reset value is high because a released bus line idles high.
module line_sync #(
    parameter WIDTH = 2
) (
    input  wire             ref_clk_i,
    input  wire             reset_n_i,
    input  wire [WIDTH-1:0] async_i,
    output wire [WIDTH-1:0] sync_o
);

    reg [WIDTH-1:0] meta_ff;
    reg [WIDTH-1:0] sync_ff;

    // The first stage feeds only the second stage.
    always @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            meta_ff <= {WIDTH{1'b1}};
            sync_ff <= {WIDTH{1'b1}};
        end else begin
            meta_ff <= async_i;
            sync_ff <= meta_ff;
        end
    end

    assign sync_o = sync_ff;

endmodule

// ===== hdl/i2c_control_wait_logic.v
// Added by the designer: the APB interface to the registers.
`timescale 1ns/100ps
`include "i2c_ctrl_defines.vh"

module i2c_control_wait_logic (
    input  wire                 ref_clk_i,
    input  wire                 reset_n_i,
    input  wire                 psel_i,
    input  wire                 penable_i,
    input  wire                 pwrite_i,
    input  wire [`ADDR_W-1:0]   paddr_i,
    input  wire [31:0]          pwdata_i,
    output wire [31:0]          prdata_o,
    output wire                 pready_o,
    output wire                 pslverr_o,
    input  wire                 serial_clock_line_i,
    output wire                 serial_clock_line_o,
    output wire                 serial_clock_line_oe_n_o,
    input  wire                 serial_data_line_i,
    output wire                 serial_data_line_o,
    output wire                 serial_data_line_oe_n_o,
    output wire                 bus_interrupt_o
);

    // Serial clock half period, rounded up to whole system clock cycles.
    localparam integer HALF_INT = ((`SCL_HALF_NS * `CLK_FREQ_KHZ) + `KHZ_NS_PER_CYCLE - 1)
                                  / `KHZ_NS_PER_CYCLE;
    localparam [15:0]  HALF_CYC = HALF_INT[15:0];

    localparam [2:0] ST_IDLE    = 3'b000;
    localparam [2:0] ST_START   = 3'b001;
    localparam [2:0] ST_MASTER  = 3'b010;
    localparam [2:0] ST_SLAVE   = 3'b011;
    localparam [2:0] ST_STOP    = 3'b100;
    localparam [2:0] ST_STANDBY = 3'b101;

    reg  [7:0]  ctl_ff;
    reg  [7:0]  sadr_ff;
    reg  [7:0]  shift_ff;
    reg  [31:0] prdata_ff;
    reg  [2:0]  state_ff;
    reg  [3:0]  bit_cnt_ff;
    reg  [15:0] tmr_ff;
    reg         scl_d_ff;
    reg         sda_d_ff;
    reg         busy_ff;
    reg         addr_phase_ff;
    reg         first_fall_ff;
    reg         rw_ff;
    reg         msts_ff;
    reg         coi_ff;
    reg         exc_ff;
    reg         trc_ff;
    reg         ackd_ff;
    reg         std_ff;
    reg         spd_ff;
    reg         wait_ff;
    reg         wait9_ff;
    reg         stop_ph_ff;
    reg         scl_pull_ff;
    reg         sda_pull_ff;
    reg         irq_ff;
    wire [1:0]  lines_s;
    wire        scl_s;
    wire        sda_s;

    line_sync #(
        .WIDTH     (2)
    ) u_line_sync (
        .ref_clk_i (ref_clk_i),
        .reset_n_i (reset_n_i),
        .async_i   ({serial_clock_line_i, serial_data_line_i}),
        .sync_o    (lines_s)
    );

    assign scl_s = lines_s[1];
    assign sda_s = lines_s[0];

    // Line events seen on the synchronised levels.
    wire scl_rise  = scl_s & ~scl_d_ff;
    wire scl_fall  = ~scl_s & scl_d_ff;
    wire start_det = scl_s & scl_d_ff & sda_d_ff & ~sda_s;
    wire stop_det  = scl_s & scl_d_ff & ~sda_d_ff & sda_s;

    // Address decisions taken on the first byte while not acting as master.
    wire listening  = (state_ff == ST_IDLE) || (state_ff == ST_STANDBY);
    wire match_now  = listening && (shift_ff[7:1] == sadr_ff[7:1]);
    wire ext_now    = listening && !match_now && (shift_ff[7:4] == `EXT_CODE_NIB);
    wire taking_part = (state_ff == ST_MASTER) || (state_ff == ST_SLAVE);
    wire fall8      = (bit_cnt_ff == `BIT_AT_8TH_FALL);
    wire fall9      = (bit_cnt_ff == `BIT_AT_9TH_FALL);

    // Wait points: the address phase has fixed points, data bytes follow the select bit.
    wire wait8 = fall8 && (addr_phase_ff ? ext_now
                                         : (taking_part && !ctl_ff[`CTL_WTIM]));
    wire wait9 = fall9 && (addr_phase_ff ? ((state_ff == ST_MASTER) ||
                                            (state_ff == ST_SLAVE && coi_ff))
                                         : (taking_part && ctl_ff[`CTL_WTIM]));

    // Level the data line should carry while the clock is low.
    wire ack_drive = !trc_ff && (addr_phase_ff ? ((state_ff == ST_SLAVE) &&
                                                  (coi_ff || (exc_ff && ctl_ff[`CTL_ACKE])))
                                               : ctl_ff[`CTL_ACKE]);
    wire drive_low = fall9 ? ack_drive : (trc_ff && !shift_ff[7]);

    // APB decode; every register answers in the access phase without wait states.
    wire setup_rd = psel_i && !penable_i && !pwrite_i;
    wire access   = psel_i && penable_i;
    wire hit_ctl  = (paddr_i == `OFS_BUS_CONTROL);
    wire hit_sts  = (paddr_i == `OFS_BUS_STATUS);
    wire hit_sadr = (paddr_i == `OFS_SLAVE_ADDR);
    wire hit_data = (paddr_i == `OFS_SHIFT_DATA);
    wire hit_any  = hit_ctl || hit_sts || hit_sadr || hit_data;
    wire wr_take  = access && pwrite_i && hit_any;
    wire [7:0] status_vec = {msts_ff, coi_ff, exc_ff, wait_ff, trc_ff, ackd_ff, std_ff, spd_ff};
    reg  [7:0] rd_mux;

    // Read data is captured in the setup phase so prdata comes from a flop.
    always @* begin
        if (hit_ctl) begin
            rd_mux = ctl_ff & `CTL_READ_MASK;
        end else if (hit_sts) begin
            rd_mux = status_vec;
        end else if (hit_sadr) begin
            rd_mux = sadr_ff;
        end else if (hit_data) begin
            rd_mux = shift_ff;
        end else begin
            rd_mux = 8'h00;
        end
    end

    always @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            prdata_ff <= 32'h0000_0000;
        end else if (setup_rd) begin
            prdata_ff <= {24'h00_0000, rd_mux};
        end
    end

    // Main control process. Later assignments override earlier ones, so the
    // order below sets priority: exit beats cancel, and software writes win.
    always @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ctl_ff        <= `CTL_RESET;
            sadr_ff       <= 8'h00;
            shift_ff      <= 8'h00;
            state_ff      <= ST_IDLE;
            bit_cnt_ff    <= 4'h0;
            tmr_ff        <= 16'h0000;
            scl_d_ff      <= 1'b1;
            sda_d_ff      <= 1'b1;
            busy_ff       <= 1'b0;
            addr_phase_ff <= 1'b0;
            first_fall_ff <= 1'b0;
            rw_ff         <= 1'b0;
            msts_ff       <= 1'b0;
            coi_ff        <= 1'b0;
            exc_ff        <= 1'b0;
            trc_ff        <= 1'b0;
            ackd_ff       <= 1'b0;
            std_ff        <= 1'b0;
            spd_ff        <= 1'b0;
            wait_ff       <= 1'b0;
            wait9_ff      <= 1'b0;
            stop_ph_ff    <= 1'b0;
            scl_pull_ff   <= 1'b0;
            sda_pull_ff   <= 1'b0;
            irq_ff        <= 1'b0;
        end else begin
            irq_ff   <= 1'b0;
            scl_d_ff <= scl_s;
            sda_d_ff <= sda_s;
            if (!ctl_ff[`CTL_ENABLE]) begin
                // Stopped: status cleared, lines released, triggers dropped.
                state_ff           <= ST_IDLE;
                {msts_ff, coi_ff, exc_ff, trc_ff} <= 4'h0;
                {ackd_ff, std_ff, spd_ff, wait_ff} <= 4'h0;
                wait9_ff           <= 1'b0;
                busy_ff            <= 1'b0;
                bit_cnt_ff         <= 4'h0;
                addr_phase_ff      <= 1'b0;
                first_fall_ff      <= 1'b0;
                scl_pull_ff        <= 1'b0;
                sda_pull_ff        <= 1'b0;
                ctl_ff[`CTL_EXIT]    <= 1'b0;
                ctl_ff[`CTL_WCANCEL] <= 1'b0;
                ctl_ff[`CTL_STT]     <= 1'b0;
                ctl_ff[`CTL_SPT]     <= 1'b0;
            end else begin
                // Data line follows the current bit while the clock is low.
                if (taking_part && !scl_s) begin
                    sda_pull_ff <= drive_low;
                end

                case (state_ff)
                    ST_IDLE: begin
                        if (ctl_ff[`CTL_STT] && !busy_ff) begin
                            state_ff    <= ST_START;
                            sda_pull_ff <= 1'b1;
                            tmr_ff      <= HALF_CYC;
                        end
                    end
                    ST_START: begin
                        if (tmr_ff != 16'h0000) begin
                            tmr_ff <= tmr_ff - 16'h0001;
                        end else begin
                            scl_pull_ff      <= 1'b1;
                            msts_ff          <= 1'b1;
                            trc_ff           <= 1'b1;
                            ctl_ff[`CTL_STT] <= 1'b0;
                            tmr_ff           <= HALF_CYC;
                            state_ff         <= ST_MASTER;
                        end
                    end
                    ST_MASTER: begin
                        if (!wait_ff) begin
                            // Clock generation; a stretched clock holds the count.
                            if (tmr_ff != 16'h0000) begin
                                if (scl_pull_ff || scl_s) begin
                                    tmr_ff <= tmr_ff - 16'h0001;
                                end
                            end else begin
                                scl_pull_ff <= ~scl_pull_ff;
                                tmr_ff      <= HALF_CYC;
                            end
                        end else if (ctl_ff[`CTL_SPT]) begin
                            state_ff    <= ST_STOP;
                            stop_ph_ff  <= 1'b0;
                            sda_pull_ff <= 1'b1;
                            wait_ff     <= 1'b0;
                            tmr_ff      <= HALF_CYC;
                        end
                    end
                    ST_STOP: begin
                        if (tmr_ff != 16'h0000) begin
                            tmr_ff <= tmr_ff - 16'h0001;
                        end else if (!stop_ph_ff) begin
                            scl_pull_ff <= 1'b0;
                            stop_ph_ff  <= 1'b1;
                            tmr_ff      <= HALF_CYC;
                        end else if (scl_s) begin
                            sda_pull_ff      <= 1'b0;
                            ctl_ff[`CTL_SPT] <= 1'b0;
                        end
                    end
                    ST_SLAVE: begin
                        // A wait ended by a data load lets go of the clock after a half period.
                        if (!wait_ff && scl_pull_ff) begin
                            if (tmr_ff != 16'h0000) begin
                                tmr_ff <= tmr_ff - 16'h0001;
                            end else begin
                                scl_pull_ff <= 1'b0;
                            end
                        end
                    end
                    default: begin
                    end
                endcase

                // Start and stop conditions seen on the bus.
                if (start_det) begin
                    busy_ff       <= 1'b1;
                    std_ff        <= 1'b1;
                    spd_ff        <= 1'b0;
                    bit_cnt_ff    <= 4'h0;
                    addr_phase_ff <= 1'b1;
                    first_fall_ff <= 1'b1;
                    if (state_ff == ST_SLAVE) begin
                        state_ff <= ST_IDLE;
                        coi_ff   <= 1'b0;
                        exc_ff   <= 1'b0;
                        trc_ff   <= 1'b0;
                    end
                end
                if (stop_det) begin
                    busy_ff     <= 1'b0;
                    spd_ff      <= 1'b1;
                    std_ff      <= 1'b0;
                    {msts_ff, coi_ff, exc_ff, trc_ff} <= 4'h0;
                    wait_ff     <= 1'b0;
                    scl_pull_ff <= 1'b0;
                    sda_pull_ff <= 1'b0;
                    state_ff    <= ST_IDLE;
                    irq_ff      <= ctl_ff[`CTL_SPIE];
                end

                // Bit sampling on the rising clock edge.
                if (scl_rise && busy_ff) begin
                    if (fall9) begin
                        if (trc_ff) begin
                            ackd_ff <= ~sda_s;
                        end
                    end else begin
                        shift_ff <= {shift_ff[6:0], sda_s};
                    end
                end

                // Falling clock edge: count bits, take address decisions, place waits.
                if (scl_fall && busy_ff && !stop_det) begin
                    if (first_fall_ff) begin
                        first_fall_ff <= 1'b0;
                    end else begin
                        if (fall9) begin
                            bit_cnt_ff    <= 4'h0;
                            addr_phase_ff <= 1'b0;
                            if (addr_phase_ff && state_ff == ST_MASTER) begin
                                trc_ff <= ~rw_ff;
                            end else if (addr_phase_ff && state_ff == ST_SLAVE) begin
                                trc_ff <= rw_ff && coi_ff;
                            end
                        end else begin
                            bit_cnt_ff <= bit_cnt_ff + 4'h1;
                        end
                        if (fall8 && addr_phase_ff) begin
                            rw_ff <= shift_ff[0];
                            if (match_now) begin
                                coi_ff   <= 1'b1;
                                state_ff <= ST_SLAVE;
                            end else if (ext_now) begin
                                exc_ff   <= 1'b1;
                                state_ff <= ST_SLAVE;
                            end
                        end
                        if (wait8 || wait9) begin
                            wait_ff     <= 1'b1;
                            wait9_ff    <= wait9;
                            scl_pull_ff <= 1'b1;
                            irq_ff      <= 1'b1;
                        end
                    end
                end

                // Wait cancel; the transmitter at the ninth clock hands the data line back.
                if (ctl_ff[`CTL_WCANCEL] && wait_ff) begin
                    wait_ff              <= 1'b0;
                    scl_pull_ff          <= 1'b0;
                    tmr_ff               <= HALF_CYC;
                    ctl_ff[`CTL_WCANCEL] <= 1'b0;
                    if (wait9_ff && trc_ff) begin
                        sda_pull_ff <= 1'b0;
                        trc_ff      <= 1'b0;
                    end
                end

                // Exit from communication overrides the hardware logic above in this cycle; the software writes below still win.
                if (ctl_ff[`CTL_EXIT]) begin
                    state_ff    <= ST_STANDBY;
                    scl_pull_ff <= 1'b0;
                    sda_pull_ff <= 1'b0;
                    wait_ff     <= 1'b0;
                    {std_ff, ackd_ff, trc_ff, coi_ff} <= 4'h0;
                    {exc_ff, msts_ff} <= 2'b00;
                    ctl_ff[`CTL_STT]  <= 1'b0;
                    ctl_ff[`CTL_SPT]  <= 1'b0;
                    ctl_ff[`CTL_EXIT] <= 1'b0;
                end
            end

            // Software writes come last so a write beats a same-cycle hardware clear.
            if (wr_take && hit_ctl) begin
                ctl_ff <= pwdata_i[7:0];
            end
            if (wr_take && hit_sadr) begin
                sadr_ff <= {pwdata_i[7:1], 1'b0};
            end
            if (wr_take && hit_data) begin
                shift_ff <= pwdata_i[7:0];
                // Loading the next byte during a wait also ends the wait. The clock stays
                // low for one more half period, so the new first bit is on the data line
                // before the clock rises; a data change with the clock high is a false start.
                if (wait_ff && ctl_ff[`CTL_ENABLE]) begin
                    wait_ff     <= 1'b0;
                    tmr_ff      <= HALF_CYC;
                end
            end
        end
    end

    // Pins are open drain: the driven level is always low, enable is active low.
    assign serial_clock_line_o      = 1'b0;
    assign serial_data_line_o       = 1'b0;
    assign serial_clock_line_oe_n_o = ~scl_pull_ff;
    assign serial_data_line_oe_n_o  = ~sda_pull_ff;
    assign bus_interrupt_o          = irq_ff;
    assign prdata_o                 = prdata_ff;
    assign pready_o                 = 1'b1;
    assign pslverr_o                = access && !hit_any;

endmodule

// ===== sim/i2c_control_wait_logic_chk.sv
`timescale 1ns/100ps
`include "i2c_ctrl_defines.vh"

module i2c_control_wait_logic_chk (
    input wire logic        ref_clk_i,
    input wire logic        reset_n_i,
    input wire logic        psel_i,
    input wire logic        penable_i,
    input wire logic        pwrite_i,
    input wire logic [15:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [31:0] prdata_o,
    input wire logic        pready_o,
    input wire logic        pslverr_o,
    input wire logic        serial_clock_line_i,
    input wire logic        serial_clock_line_o,
    input wire logic        serial_clock_line_oe_n_o,
    input wire logic        serial_data_line_i,
    input wire logic        serial_data_line_o,
    input wire logic        serial_data_line_oe_n_o,
    input wire logic        bus_interrupt_o
);
    logic en_ff;
    logic spie_ff;
    wire  acc = psel_i && penable_i;
    wire  rel = serial_clock_line_oe_n_o && serial_data_line_oe_n_o;
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!reset_n_i);
    // Shadow of the enable and stop interrupt bits, so gating can be judged from ports only.
    always @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            en_ff   <= 1'b0;
            spie_ff <= 1'b0;
        end else if (acc && pwrite_i && paddr_i == `OFS_BUS_CONTROL) begin
            en_ff   <= pwdata_i[7];
            spie_ff <= pwdata_i[4];
        end
    end
    sequence s_ctl_wr;
        acc && pwrite_i && paddr_i == `OFS_BUS_CONTROL;
    endsequence
    a_exit_release: assert property (s_ctl_wr ##0 pwdata_i[7:6] == 2'b11 |-> ##[1:4] rel)
        else $error("lines not released after exit");
    a_disable_release: assert property (s_ctl_wr ##0 !pwdata_i[7] |-> ##[1:4] rel)
        else $error("lines not released after disable");
    a_off_idle: assert property ((!en_ff) [*3] |-> rel)
        else $error("line driven while disabled");
    a_irq_pulse: assert property (bus_interrupt_o |=> !bus_interrupt_o)
        else $error("interrupt longer than one cycle");
    a_stop_gate: assert property (bus_interrupt_o && serial_clock_line_i |-> spie_ff)
        else $error("stop interrupt while disabled by stop_irq_enable");
    a_start_order: assert property ($fell(serial_data_line_oe_n_o) && serial_clock_line_oe_n_o
        |=> serial_clock_line_oe_n_o [*8]) else $error("clock pulled low too soon after start");
    a_wait_hold: assert property ($rose(bus_interrupt_o) && !serial_clock_line_i
        |-> !serial_clock_line_oe_n_o) else $error("clock not held low at wait");
    a_ready_high: assert property (pready_o)
        else $error("pready low");
    a_slverr_map: assert property (acc |-> pslverr_o == !(paddr_i inside {`OFS_BUS_CONTROL,
        `OFS_BUS_STATUS, `OFS_SLAVE_ADDR, `OFS_SHIFT_DATA})) else $error("pslverr wrong");
    a_upper_zero: assert property (prdata_o[31:8] == 24'h0000_00)
        else $error("upper read data not zero");
endmodule

bind i2c_control_wait_logic i2c_control_wait_logic_chk chk_inst (.*);

// ===== sim/i2c_peer_slave.sv
`timescale 1ns/100ps

module i2c_peer_slave (
    input  wire logic scl_i,
    input  wire logic sda_i,
    output logic      sda_rel_o
);
    int   cnt = 0;
    logic act = 1'b0;
    initial sda_rel_o = 1'b1;
    // A data edge while the clock line is high is a start (falling) or a stop (rising).
    // The start's own clock fall is no data clock, so the count begins one below zero.
    always @(sda_i) begin
        if (scl_i === 1'b1) begin
            act = !sda_i;
            cnt = -1;
        end
    end
    // Acknowledge every byte; the data line goes back to the pull-up after the ninth clock.
    always @(negedge scl_i) begin
        if (act) begin
            cnt = cnt + 1;
            sda_rel_o = (cnt != 8);
            if (cnt == 9) cnt = 0;
        end
    end
endmodule

// ===== sim/i2c_control_wait_logic_tb.sv
`timescale 1ns/100ps

module i2c_control_wait_logic_tb;
    logic        ref_clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0;
    logic [15:0] paddr = 16'h0000;
    logic [31:0] pwdata = 32'h0000_0000, q;
    logic        e;
    wire  [31:0] prdata;
    wire         pready, pslverr, scl_o, scl_oe_n, sda_o, sda_oe_n, irq, peer_rel;
    wire         scl_w = scl_oe_n | scl_o;
    wire         sda_w = (sda_oe_n | sda_o) & peer_rel;
    int          n_errors = 0, num_checks = 0, nfall = 0;
    always #10 ref_clk = ~ref_clk;
    // Falling clock edges on the wire, counted to place each wait.
    always @(negedge scl_w) nfall = nfall + 1;
    i2c_control_wait_logic i2c_control_wait_logic_inst (.ref_clk_i(ref_clk),
        .reset_n_i(reset_n), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
        .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
        .pslverr_o(pslverr), .serial_clock_line_i(scl_w), .serial_clock_line_o(scl_o),
        .serial_clock_line_oe_n_o(scl_oe_n), .serial_data_line_i(sda_w),
        .serial_data_line_o(sda_o), .serial_data_line_oe_n_o(sda_oe_n), .bus_interrupt_o(irq));
    i2c_peer_slave i2c_peer_slave_inst (.scl_i(scl_w), .sda_i(sda_w), .sda_rel_o(peer_rel));
    // One APB transfer; the request is held until pready is seen high.
    task apb(input logic w, input logic [15:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge ref_clk);
        penable <= 1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 0; penable <= 0;
    endtask
    task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // Waits are bounded by the watchdog, which fires at 40000 cycles, well after a normal run would have ended.
    task wait_irq;
        do @(negedge ref_clk); while (irq !== 1'b1);
    endtask
    task print_verdict;
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    initial begin
        repeat (40000) @(posedge ref_clk);
        n_errors++;
        print_verdict;
    end
    // Main sequence: register map, gating while off, waits, stop, exit, disable.
    initial begin
        repeat (6) @(posedge ref_clk);
        reset_n <= 1;
        apb(0, 16'hffa8, 0); chk("ctl reset", 32'h0000_0000, q);
        apb(0, 16'h0000, 0); chk("unmapped err", 1, e); chk("unmapped rd", 0, q);
        apb(1, 16'hffa8, 32'h0000_007f); apb(0, 16'hffa8, 0); chk("ctl off", 32'h1c, q);
        repeat (300) @(negedge ref_clk);
        chk("sda idle off", 1, sda_oe_n); chk("falls off", 0, nfall);
        apb(1, 16'hffb4, 32'h0000_00a0); nfall = 0;
        // The start's clock fall is counted too, so the ninth clock fall is the tenth fall.
        apb(1, 16'hffa8, 32'h0000_0092); wait_irq; chk("addr falls", 10, nfall);
        apb(0, 16'hffac, 0); chk("sts addr", 32'h9c, q & 32'h9c);
        nfall = 0; apb(1, 16'hffb4, 32'h0000_0055); wait_irq; chk("8th", 8, nfall);
        nfall = 0; apb(1, 16'hffa8, 32'h0000_00b8); wait_irq; chk("9th", 1, nfall);
        apb(0, 16'hffa8, 0); chk("cancel clr", 32'h98, q);
        apb(1, 16'hffa8, 32'h0000_0099); wait_irq; chk("stop lines", 1, scl_w & sda_w);
        apb(0, 16'hffac, 0); chk("sts stop", 0, q & 32'h80);
        apb(1, 16'hffb4, 32'h0000_00a0); nfall = 0;
        apb(1, 16'hffa8, 32'h0000_008a); wait_irq; chk("addr falls 1", 10, nfall);
        apb(0, 16'hffac, 0); chk("master", 32'h80, q & 32'h80);
        apb(1, 16'hffa8, 32'h0000_00c8);
        repeat (8) @(negedge ref_clk);
        chk("exit lines", 2'b11, {scl_oe_n, sda_oe_n});
        apb(0, 16'hffa8, 0); chk("exit clr", 32'h88, q);
        apb(0, 16'hffac, 0); chk("exit sts", 0, q & 32'hee);
        apb(1, 16'hffa8, 0); apb(0, 16'hffac, 0); chk("off sts", 0, q);
        print_verdict;
    end
endmodule
